// ### include/autoneg_pkg.sv
// Summary of operation
// - Strap level sampled at reset loads advertisement bits [8:5].
// - Strap 0 advertises half duplex only; strap 1 all four modes.
// - Control register at 0x00 changes negotiation setting at any time.
// - Bursts carry exactly the advertisement register at 04h.
// - Resolution priority: 100 full, 100 half, 10 full, 10 half.
// - Negotiation off: control speed and duplex bits set the mode.
// - Negotiation on: control speed and duplex bits are ignored.
// - After link, status register 10h reports the link speed.
// - Ability bits read as ones, except 100BASE-T4 which reads zero.
// - Basic status shows complete, remote fault, link, preamble skip.
// - Advertisement resets to the strap-selected abilities; cleared bits stop offering.
// - Partner register 0x05 captures base and next page words.
// - Parallel detect loads partner register with 0081h or 0021h.
// - Expansion flags detect fault, both next page, page, partner able.
// - Clearing control bit 10 leaves isolate within 100 us.
// - Reset release leaves isolate within 500 us.
// - MII or RMII chosen by strap at reset or by register.
// - Writing one to control bit 9 restarts negotiation.
// - Renegotiation halts transmit until break link timer, then bursts.
// - After parallel detect, partner able reads zero while complete.
// - Loss of link after negotiation restarts negotiation.
package autoneg_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [4:0] ADDR_CTRL = 5'h00;
    localparam logic [4:0] ADDR_STAT = 5'h01;
    localparam logic [4:0] ADDR_ADV = 5'h04;
    localparam logic [4:0] ADDR_LPA = 5'h05;
    localparam logic [4:0] ADDR_EXP = 5'h06;
    localparam logic [4:0] ADDR_PHY_STAT = 5'h10;
    localparam logic [4:0] ADDR_MACCFG = 5'h17;

    localparam int CTRL_RESET = 15;
    localparam int CTRL_SPEED = 13;
    localparam int CTRL_AN_EN = 12;
    localparam int CTRL_ISO = 10;
    localparam int CTRL_RESTART = 9;
    localparam int CTRL_DUPLEX = 8;
    localparam int MACCFG_RMII = 5;
    localparam int ADV_LO = 5;
    localparam int ADV_HI = 8;

    localparam logic [15:0] CTRL_RST_VAL = 16'h3100;
    localparam logic [15:0] CTRL_WMASK = 16'h7D00;
    localparam logic [15:0] ADV_BASE = 16'h0001;
    localparam logic [3:0] ADV_STRAP0 = 4'h5;
    localparam logic [3:0] ADV_STRAP1 = 4'hF;
    localparam logic [15:0] STAT_FIXED = 16'h7849;
    localparam logic [15:0] PD_100_WORD = 16'h0081;
    localparam logic [15:0] PD_10_WORD = 16'h0021;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_MHZ = 25;
    localparam int ISO_CLEAR_US = 100;
    localparam int ISO_RESET_US = 500;
    localparam int BREAK_LINK_MS = 1500;
    localparam int ISO_CLEAR_CYCLES = ISO_CLEAR_US * CLK_MHZ;
    localparam int ISO_RESET_CYCLES = ISO_RESET_US * CLK_MHZ;
    localparam int BREAK_CYCLES = BREAK_LINK_MS * 1000 * CLK_MHZ;

    typedef enum logic [2:0] {
        ST_FORCED = 3'b000,
        ST_BREAK = 3'b001,
        ST_ABILITY = 3'b010,
        ST_WAIT_LINK = 3'b011,
        ST_DONE = 3'b100
    } an_state_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [4:0] addr;
        logic [15:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic valid;
        logic [15:0] word;
    } page_in_t;

    typedef struct packed {
        logic speed_100;
        logic full_duplex;
    } mode_t;

endpackage

// ### hdl/autoneg_control_status.sv
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
module autoneg_control_status #(
    parameter int BREAK_LINK_CYCLES = autoneg_pkg::BREAK_CYCLES,
    parameter int RESET_ISO_CYCLES = autoneg_pkg::ISO_RESET_CYCLES,
    parameter bit LOCAL_NP_ABLE = 1'b0
) (
    input wire logic clk, // 25 MHz clock
    input wire logic rst_n, // Synchronous reset, active low
    input wire autoneg_pkg::reg_req_t bus_req, // Register request
    output logic [15:0] rd_data, // Read data, cycle after read
    input wire logic negotiation_strap_pin, // Advertisement strap
    input wire logic mac_mode_strap, // 1 selects RMII at reset
    input wire autoneg_pkg::page_in_t page_in, // Received code word
    input wire logic link_100_ok, // 100 Mb/s receiver sees link
    input wire logic link_10_ok, // 10 Mb/s receiver sees link
    output logic [15:0] adv_word, // Word sent in bursts
    output logic flp_enable, // Send link pulse bursts
    output logic tx_halt, // Halt all transmit activity
    output autoneg_pkg::mode_t op_mode, // Operating speed and duplex
    output logic an_complete, // Negotiation complete
    output logic isolate, // Isolate from the MAC
    output logic rmii_mode // MAC interface is RMII
);

    // ****************************************************************
    // Checks and helpers
    // ****************************************************************
    if (BREAK_LINK_CYCLES < 2 || RESET_ISO_CYCLES < 2) begin : g_bad
        $error("cycle counts must be at least two");
    end

    function automatic autoneg_pkg::mode_t resolve(input logic [3:0] c);
        autoneg_pkg::mode_t m;
        m = '0;
        if (c[3]) begin
            m = '{speed_100: 1'b1, full_duplex: 1'b1};
        end else if (c[2]) begin
            m = '{speed_100: 1'b1, full_duplex: 1'b0};
        end else if (c[1]) begin
            m = '{speed_100: 1'b0, full_duplex: 1'b1};
        end
        return m;
    endfunction

    localparam logic [31:0] BREAK_LOAD = 32'(BREAK_LINK_CYCLES - 1);
    localparam logic [31:0] ISO_RST_LOAD = 32'(RESET_ISO_CYCLES - 1);
    localparam logic [31:0] ISO_CLR_LOAD =
        32'(autoneg_pkg::ISO_CLEAR_CYCLES - 1);

    autoneg_pkg::an_state_t state_q, state_d;
    logic sw_rst_q;
    logic [15:0] ctrl_q, advert_q, partner_q;
    logic lp_able_q, page_rx_q, pdf_q, pd_done_q, lp_np_q, rmii_q;
    logic [31:0] tmr_q, iso_cnt_q;
    autoneg_pkg::mode_t mode_d;

    // ****************************************************************
    // Register decode
    // ****************************************************************
    wire rst_all = !rst_n || sw_rst_q;
    wire wr_ctrl = bus_req.wr && bus_req.addr == autoneg_pkg::ADDR_CTRL;
    wire wr_adv = bus_req.wr && bus_req.addr == autoneg_pkg::ADDR_ADV;
    wire wr_mac = bus_req.wr && bus_req.addr == autoneg_pkg::ADDR_MACCFG;
    wire rd_exp = bus_req.rd && bus_req.addr == autoneg_pkg::ADDR_EXP;
    wire an_en = ctrl_q[autoneg_pkg::CTRL_AN_EN];
    wire sw_rst_req = wr_ctrl && bus_req.wdata[autoneg_pkg::CTRL_RESET];
    wire an_rise = wr_ctrl && bus_req.wdata[autoneg_pkg::CTRL_AN_EN]
        && !an_en;
    wire restart_req = wr_ctrl && an_en
        && bus_req.wdata[autoneg_pkg::CTRL_RESTART];
    wire iso_clear = wr_ctrl && ctrl_q[autoneg_pkg::CTRL_ISO]
        && !bus_req.wdata[autoneg_pkg::CTRL_ISO];
    wire [3:0] common = advert_q[autoneg_pkg::ADV_HI:autoneg_pkg::ADV_LO]
        & partner_q[autoneg_pkg::ADV_HI:autoneg_pkg::ADV_LO];
    wire page_common = (advert_q[autoneg_pkg::ADV_HI:autoneg_pkg::ADV_LO]
        & page_in.word[autoneg_pkg::ADV_HI:autoneg_pkg::ADV_LO]) != 4'h0;
    wire autoneg_pkg::mode_t resolved = resolve(common);
    wire autoneg_pkg::mode_t forced = '{
        speed_100: ctrl_q[autoneg_pkg::CTRL_SPEED],
        full_duplex: ctrl_q[autoneg_pkg::CTRL_DUPLEX]};
    wire res_link = resolved.speed_100 ? link_100_ok : link_10_ok;
    wire forced_link = forced.speed_100 ? link_100_ok : link_10_ok;
    wire pd_one = (link_100_ok ^ link_10_ok) && !page_rx_q;
    wire pd_both = link_100_ok && link_10_ok && !page_rx_q;
    wire base_page = page_in.valid && !page_rx_q;
    wire link_up = state_q == autoneg_pkg::ST_DONE
        || (state_q == autoneg_pkg::ST_FORCED && forced_link);
    wire rfault = partner_q[13] && lp_able_q;
    wire enter_ability = state_d == autoneg_pkg::ST_ABILITY
        && state_q != autoneg_pkg::ST_ABILITY;

    wire [15:0] stat_word = autoneg_pkg::STAT_FIXED
        | {10'h000, an_complete, rfault, 1'b0, link_up, 2'b00};
    wire [15:0] exp_word = {11'h000, pdf_q, lp_np_q, LOCAL_NP_ABLE,
        page_rx_q, lp_able_q};
    wire [15:0] phy_stat_word = {11'h000, an_complete, 1'b0,
        op_mode.full_duplex, !op_mode.speed_100, link_up};
    wire [15:0] rd_mux =
        bus_req.addr == autoneg_pkg::ADDR_CTRL ? ctrl_q :
        bus_req.addr == autoneg_pkg::ADDR_STAT ? stat_word :
        bus_req.addr == autoneg_pkg::ADDR_ADV ? advert_q :
        bus_req.addr == autoneg_pkg::ADDR_LPA ? partner_q :
        bus_req.addr == autoneg_pkg::ADDR_EXP ? exp_word :
        bus_req.addr == autoneg_pkg::ADDR_PHY_STAT ? phy_stat_word :
        bus_req.addr == autoneg_pkg::ADDR_MACCFG ?
        16'(rmii_q) << autoneg_pkg::MACCFG_RMII : 16'h0000;

    // ****************************************************************
    // Negotiation sequencing
    // ****************************************************************
    always_comb begin
        state_d = state_q;
        case (state_q)
            autoneg_pkg::ST_FORCED: begin
                if (an_rise) begin
                    state_d = autoneg_pkg::ST_BREAK;
                end
            end
            autoneg_pkg::ST_BREAK: begin
                if (tmr_q == 32'h0000_0000) begin
                    state_d = autoneg_pkg::ST_ABILITY;
                end
            end
            autoneg_pkg::ST_ABILITY: begin
                if (base_page && page_common) begin
                    state_d = autoneg_pkg::ST_WAIT_LINK;
                end else if (pd_one) begin
                    state_d = autoneg_pkg::ST_DONE;
                end
            end
            autoneg_pkg::ST_WAIT_LINK: begin
                if (res_link) begin
                    state_d = autoneg_pkg::ST_DONE;
                end
            end
            autoneg_pkg::ST_DONE: begin
                if (!res_link) begin
                    state_d = autoneg_pkg::ST_ABILITY;
                end
            end
            default: begin
                state_d = autoneg_pkg::ST_FORCED;
            end
        endcase
        if (!an_en && !an_rise) begin
            state_d = autoneg_pkg::ST_FORCED;
        end else if (restart_req) begin
            state_d = autoneg_pkg::ST_BREAK;
        end
    end

    always_comb begin
        if (!an_en) begin
            mode_d = forced;
        end else if (state_q == autoneg_pkg::ST_DONE) begin
            mode_d = resolved;
        end else begin
            mode_d = '0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst_all) begin
            state_q <= autoneg_pkg::ST_ABILITY;
            tmr_q <= '0;
        end else begin
            state_q <= state_d;
            tmr_q <= state_d == autoneg_pkg::ST_BREAK
                && state_q != autoneg_pkg::ST_BREAK ? BREAK_LOAD
                : tmr_q - 32'(tmr_q != '0);
        end
    end

    // ****************************************************************
    // Management registers
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (rst_all) begin
            ctrl_q <= autoneg_pkg::CTRL_RST_VAL;
            advert_q <= autoneg_pkg::ADV_BASE;
            advert_q[8:5] <= negotiation_strap_pin ? autoneg_pkg::ADV_STRAP1
                : autoneg_pkg::ADV_STRAP0;
            rmii_q <= mac_mode_strap;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= bus_req.wdata & autoneg_pkg::CTRL_WMASK;
            end
            if (wr_adv) begin
                advert_q <= bus_req.wdata;
            end
            if (wr_mac) begin
                rmii_q <= bus_req.wdata[autoneg_pkg::MACCFG_RMII];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst_all) begin
            partner_q <= '0;
            lp_able_q <= 1'b0;
            page_rx_q <= 1'b0;
            pd_done_q <= 1'b0;
            lp_np_q <= 1'b0;
            pdf_q <= 1'b0;
        end else begin
            if (enter_ability) begin
                page_rx_q <= 1'b0;
                lp_able_q <= 1'b0;
                pd_done_q <= 1'b0;
            end else if (state_q == autoneg_pkg::ST_ABILITY && pd_one) begin
                partner_q <= link_100_ok ? autoneg_pkg::PD_100_WORD
                    : autoneg_pkg::PD_10_WORD;
                pd_done_q <= 1'b1;
                lp_able_q <= 1'b0;
            end else if (page_in.valid && an_en) begin
                partner_q <= page_in.word;
                page_rx_q <= 1'b1;
                lp_able_q <= 1'b1;
                lp_np_q <= base_page ? page_in.word[15] : lp_np_q;
            end
            if (state_q == autoneg_pkg::ST_ABILITY && pd_both) begin
                pdf_q <= 1'b1;
            end else if (rd_exp) begin
                pdf_q <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Isolate timing and outputs
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (rst_all) begin
            iso_cnt_q <= ISO_RST_LOAD;
            isolate <= 1'b1;
        end else begin
            iso_cnt_q <= iso_clear ? ISO_CLR_LOAD
                : iso_cnt_q - 32'(iso_cnt_q != '0);
            isolate <= ctrl_q[autoneg_pkg::CTRL_ISO] || iso_cnt_q != '0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sw_rst_q <= 1'b0;
            rd_data <= '0;
        end else begin
            sw_rst_q <= sw_rst_req;
            rd_data <= bus_req.rd ? rd_mux : 16'h0000;
        end
    end

    always_ff @(posedge clk) begin
        if (rst_all) begin
            adv_word <= '0;
            flp_enable <= 1'b0;
            tx_halt <= 1'b0;
            op_mode <= '0;
            an_complete <= 1'b0;
            rmii_mode <= 1'b0;
        end else begin
            adv_word <= advert_q;
            flp_enable <= state_q == autoneg_pkg::ST_ABILITY;
            tx_halt <= state_q == autoneg_pkg::ST_BREAK;
            op_mode <= mode_d;
            an_complete <= an_en && state_q == autoneg_pkg::ST_DONE;
            rmii_mode <= rmii_q;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    a_strap_advert: assert property (
        @(posedge clk) disable iff (!rst_n || sw_rst_q)
        $rose(rst_n) |-> advert_q[8:5] == ($past(negotiation_strap_pin)
            ? autoneg_pkg::ADV_STRAP1 : autoneg_pkg::ADV_STRAP0))
        else $error("advertised abilities do not follow the strap");

    a_forced_mode: assert property (
        @(posedge clk) disable iff (!rst_n || sw_rst_q)
        !an_en && !wr_ctrl |=> op_mode == $past(forced))
        else $error("forced mode not taken from control bits");

    a_resolve_top: assert property (
        @(posedge clk) disable iff (!rst_n || sw_rst_q)
        an_en && state_q == autoneg_pkg::ST_DONE && common[3] && !wr_ctrl
        |=> op_mode.speed_100 && op_mode.full_duplex)
        else $error("highest common mode not chosen");

    a_break_halt: assert property (
        @(posedge clk) disable iff (!rst_n || sw_rst_q)
        restart_req |=> ##1 tx_halt && !flp_enable)
        else $error("restart did not halt transmission");

    a_pd_word: assert property (
        @(posedge clk) disable iff (!rst_n || sw_rst_q)
        state_q == autoneg_pkg::ST_ABILITY && pd_one && link_100_ok
        && !enter_ability |=> partner_q == autoneg_pkg::PD_100_WORD)
        else $error("parallel detect word not loaded");

    a_pd_not_able: assert property (
        @(posedge clk) disable iff (!rst_n || sw_rst_q)
        an_complete && pd_done_q |-> !lp_able_q)
        else $error("partner able set after parallel detect");

    a_link_loss: assert property (
        @(posedge clk) disable iff (!rst_n || sw_rst_q)
        an_en && state_q == autoneg_pkg::ST_DONE && !res_link
        && !wr_ctrl |=> state_q == autoneg_pkg::ST_ABILITY)
        else $error("link loss did not resume negotiation");

    a_iso_bound: assert property (
        @(posedge clk) disable iff (!rst_n || sw_rst_q)
        iso_cnt_q == '0 && !ctrl_q[autoneg_pkg::CTRL_ISO] && !rst_all
        |=> !isolate)
        else $error("isolate held past its time");

    a_iso_clear: assert property (
        @(posedge clk) disable iff (!rst_n || sw_rst_q)
        iso_clear |=> iso_cnt_q == ISO_CLR_LOAD && isolate)
        else $error("isolate exit timer not started");

    a_adv_copy: assert property (
        @(posedge clk) disable iff (!rst_n || sw_rst_q)
        !rst_all |=> adv_word == $past(advert_q))
        else $error("burst word differs from advertisement");

    a_halt_state: assert property (
        @(posedge clk) disable iff (!rst_n || sw_rst_q)
        !rst_all |=> tx_halt == ($past(state_q) == autoneg_pkg::ST_BREAK))
        else $error("transmit halt does not follow break state");

    a_pdf_set: assert property (
        @(posedge clk) disable iff (!rst_n || sw_rst_q)
        state_q == autoneg_pkg::ST_ABILITY && pd_both && !rst_all
        |=> pdf_q)
        else $error("parallel detect fault not flagged");

    a_rd_idle: assert property (
        @(posedge clk) disable iff (!rst_n || sw_rst_q)
        !bus_req.rd |=> rd_data == 16'h0000)
        else $error("read data not zero outside a read");

endmodule

// ### testbench/link_partner_model.sv
`timescale 1ns/1ps
module link_partner_model (
    input wire logic clk, // Shared clock
    input wire logic rst_n, // Reset, active low
    input wire logic flp_enable, // Local bursts on the wire
    input wire logic tx_halt, // Local side silent
    input wire logic [15:0] lp_word, // Base page to offer
    input wire logic lp_able, // Partner negotiates
    input wire logic [1:0] lp_link, // Link signals sent {100, 10}
    input wire logic [7:0] lp_delay, // Cycles before answering
    output autoneg_pkg::page_in_t page_in, // Received code word
    output logic link_100_ok, // 100 Mb/s link seen
    output logic link_10_ok // 10 Mb/s link seen
);
    // ****************************************************************
    // Page and link generation
    // ****************************************************************
    logic [7:0] wait_q;
    logic sent_q;
    logic link_on;

    // A silent local side makes the partner drop link and start over.
    assign link_on = (sent_q || !lp_able) && !tx_halt && rst_n;
    always_ff @(posedge clk) begin
        page_in.valid <= 1'b0;
        page_in.word <= ~page_in.word;
        {link_100_ok, link_10_ok} <= link_on ? lp_link : 2'b00;
        if (!rst_n || tx_halt || lp_link == 2'b00) begin
            wait_q <= 8'h00;
            sent_q <= 1'b0;
            page_in.word <= 16'h0000;
        end else if (lp_able && flp_enable && !sent_q) begin
            if (wait_q == lp_delay) begin
                page_in.valid <= 1'b1;
                page_in.word <= lp_word;
                sent_q <= 1'b1;
            end else begin
                wait_q <= wait_q + 8'h01;
            end
        end
    end
endmodule

// ### testbench/autoneg_control_status_tb.sv
`timescale 1ns/1ps
module autoneg_control_status_tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic strap = 1'b1;
    logic mac_strap = 1'b0;
    autoneg_pkg::reg_req_t req = '0;
    autoneg_pkg::page_in_t page_in;
    autoneg_pkg::mode_t op_mode;
    logic [15:0] rd_data, adv_word;
    logic l100, l10, flp_enable, tx_halt, an_complete, isolate, rmii_mode;
    logic [15:0] lp_word = 16'h0000;
    logic lp_able = 1'b0;
    logic [1:0] lp_link = 2'b00;
    logic [7:0] lp_delay = 8'h01;
    int err_total = 0;
    int comparisons = 0;
    int cycles = 0;

    autoneg_control_status #(.BREAK_LINK_CYCLES(16), .RESET_ISO_CYCLES(8))
    autoneg_control_status_i (.clk(clk), .rst_n(rst_n), .bus_req(req),
        .rd_data(rd_data), .negotiation_strap_pin(strap),
        .mac_mode_strap(mac_strap), .page_in(page_in), .link_100_ok(l100),
        .link_10_ok(l10), .adv_word(adv_word), .flp_enable(flp_enable),
        .tx_halt(tx_halt), .op_mode(op_mode), .an_complete(an_complete),
        .isolate(isolate), .rmii_mode(rmii_mode));

    link_partner_model link_partner_model_i (.clk(clk), .rst_n(rst_n),
        .flp_enable(flp_enable), .tx_halt(tx_halt), .lp_word(lp_word),
        .lp_able(lp_able), .lp_link(lp_link), .lp_delay(lp_delay),
        .page_in(page_in), .link_100_ok(l100), .link_10_ok(l10));

    initial begin
        forever #20 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_total = err_total + 1;
            give_verdict();
        end
    end

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        comparisons = comparisons + 1;
        if (seen !== exp) begin
            err_total = err_total + 1;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk);
        req <= {1'b1, 1'b0, a, d};
        @(posedge clk);
        req.wr <= 1'b0;
    endtask

    task automatic rchk(input logic [4:0] a, input logic [15:0] m,
            input logic [15:0] exp);
        @(posedge clk);
        req <= {1'b0, 1'b1, a, 16'h0000};
        @(posedge clk);
        req.rd <= 1'b0;
        #1;
        chk(rd_data & m, exp);
    endtask

    task automatic wait_done();
        for (int n = 0; n < 300 && an_complete !== 1'b1; n++) begin
            wt(1);
        end
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_reset(input logic s, input logic m);
        logic [15:0] adv;
        adv = s ? 16'h01E1 : 16'h00A1;
        @(posedge clk);
        lp_link <= 2'b00;
        rst_n <= 1'b0;
        strap <= s;
        mac_strap <= m;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        wt(2);
        chk(16'(isolate), 16'h0001);
        chk(16'(rmii_mode), 16'(m));
        chk(adv_word, adv);
        rchk(autoneg_pkg::ADDR_CTRL, 16'hFFFF, 16'h3100);
        rchk(autoneg_pkg::ADDR_ADV, 16'hFFFF, adv);
        rchk(autoneg_pkg::ADDR_STAT, 16'hFFFF, 16'h7849);
        rchk(5'h1F, 16'hFFFF, 16'h0000);
        wt(2);
        chk(16'(isolate), 16'h0000);
        $display("reset test done");
    endtask

    task automatic t_neg(input logic [15:0] w, input logic able,
            input logic [1:0] lk, input logic [1:0] md,
            input logic [15:0] lpa);
        logic [15:0] phy;
        phy = 16'h0011 | (md[1] ? 16'h0000 : 16'h0002);
        phy = phy | (md[0] ? 16'h0004 : 16'h0000);
        wr(autoneg_pkg::ADDR_CTRL, 16'h1200);
        lp_word <= w;
        lp_able <= able;
        lp_link <= lk;
        lp_delay <= lp_delay ^ 8'h1F;
        wt(3);
        chk(16'({tx_halt, flp_enable}), 16'h0002);
        wait_done();
        chk(16'({an_complete, tx_halt}), 16'h0002);
        chk(16'(op_mode), 16'(md));
        rchk(autoneg_pkg::ADDR_LPA, 16'hFFFF, lpa);
        rchk(autoneg_pkg::ADDR_PHY_STAT, 16'hFFFF, phy);
        $display("negotiation test done");
    endtask

    task automatic t_status();
        rchk(autoneg_pkg::ADDR_STAT, 16'hFFFF, 16'h787D);
        rchk(autoneg_pkg::ADDR_EXP, 16'hFFFF, 16'h000B);
        wr(autoneg_pkg::ADDR_CTRL, 16'h1000);
        wt(3);
        chk(16'(op_mode), 16'h0003);
        $display("status test done");
    endtask

    task automatic t_lose();
        lp_link <= 2'b00;
        wt(6);
        chk(16'(an_complete), 16'h0000);
        for (int n = 0; n < 60 && flp_enable !== 1'b1; n++) begin
            wt(1);
        end
        chk(16'(flp_enable), 16'h0001);
        lp_link <= 2'b01;
        wait_done();
        chk(16'(an_complete), 16'h0001);
        $display("link loss test done");
    endtask

    task automatic t_pd();
        t_neg(16'h0000, 1'b0, 2'b01, 2'b00, 16'h0021);
        rchk(autoneg_pkg::ADDR_EXP, 16'h0001, 16'h0000);
        rchk(autoneg_pkg::ADDR_STAT, 16'h0020, 16'h0020);
        t_neg(16'h0000, 1'b0, 2'b10, 2'b10, 16'h0081);
        wr(autoneg_pkg::ADDR_CTRL, 16'h1200);
        lp_link <= 2'b11;
        wt(40);
        rchk(autoneg_pkg::ADDR_EXP, 16'h0010, 16'h0010);
        $display("parallel detect test done");
    endtask

    task automatic t_adv();
        wr(autoneg_pkg::ADDR_ADV, 16'h0021);
        wt(3);
        chk(adv_word, 16'h0021);
        rchk(autoneg_pkg::ADDR_ADV, 16'hFFFF, 16'h0021);
        t_neg(16'h01E1, 1'b1, 2'b01, 2'b00, 16'h01E1);
        wr(autoneg_pkg::ADDR_ADV, 16'h01E1);
        $display("advertisement test done");
    endtask

    task automatic t_forced();
        logic [1:0] m;
        lp_link <= 2'b00;
        for (int i = 0; i < 4; i++) begin
            m = 2'(i);
            wr(autoneg_pkg::ADDR_CTRL, {2'b00, m[1], 4'b0000, m[0], 8'h00});
            wt(3);
            chk(16'(op_mode), 16'(m));
            chk(16'(flp_enable), 16'h0000);
        end
        wr(autoneg_pkg::ADDR_CTRL, 16'h3100);
        wt(3);
        chk(16'(tx_halt), 16'h0001);
        $display("forced mode test done");
    endtask

    task automatic t_iso();
        wr(autoneg_pkg::ADDR_CTRL, 16'h3500);
        wt(3);
        chk(16'(isolate), 16'h0001);
        wr(autoneg_pkg::ADDR_CTRL, 16'h3100);
        wt(2505);
        chk(16'(isolate), 16'h0000);
        $display("isolate test done");
    endtask

    task automatic t_regs();
        wr(autoneg_pkg::ADDR_MACCFG, 16'h0020);
        wt(3);
        chk(16'(rmii_mode), 16'h0001);
        wr(autoneg_pkg::ADDR_MACCFG, 16'h0000);
        wt(3);
        chk(16'(rmii_mode), 16'h0000);
        wr(autoneg_pkg::ADDR_LPA, 16'hFFFF);
        rchk(autoneg_pkg::ADDR_LPA, 16'hFFFF, 16'h01E1);
        wr(autoneg_pkg::ADDR_CTRL, 16'h8000);
        wt(3);
        chk(16'(isolate), 16'h0001);
        wt(12);
        chk(16'(isolate), 16'h0000);
        $display("register test done");
    endtask

    initial begin
        t_reset(1'b1, 1'b0);
        t_neg(16'hA1E1, 1'b1, 2'b10, 2'b11, 16'hA1E1);
        t_status();
        t_neg(16'h00A1, 1'b1, 2'b10, 2'b10, 16'h00A1);
        t_neg(16'h0061, 1'b1, 2'b01, 2'b01, 16'h0061);
        t_neg(16'h0021, 1'b1, 2'b01, 2'b00, 16'h0021);
        t_lose();
        t_pd();
        t_adv();
        t_forced();
        t_iso();
        t_regs();
        t_reset(1'b0, 1'b1);
        give_verdict();
    end
endmodule
